/* File: src/compare_capture_timer.sv */
// Free-running 16-bit timer with compare, capture and pin control
`timescale 1ns/1ps
module compare_capture_timer
(
    input wire logic ref_clk,
    input wire logic reset,
    timer_bus_if.timer bus,
    input wire logic ext_count_tick,
    input wire logic shared_pin_in,
    output logic shared_pin_out,
    output logic shared_pin_oe
);
    import timer_pkg::*;

    logic [7:0] port3_direction;
    logic [7:0] port3_latch;
    logic [15:0] free_counter;
    logic [15:0] compare_value;
    logic [15:0] capture_value;
    logic [15:0] read_buffer;
    logic buffer_frozen;
    logic output_enable_bit;
    logic output_toggle_enable;
    logic wrap_flag;
    logic output_level_bit;
    logic [1:0] count_clk_sel;
    logic [1:0] edge_sel;
    logic [4:0] prescale;
    logic [1:0] tick_sync;
    logic tick_prev;
    logic [1:0] pin_sync;
    logic pin_prev;
    logic count_tick;
    logic capture_edge;
    logic match_now;
    logic match_prev;
    logic rd_prev;
    logic [15:0] last_rd_addr;
    logic mode_write;

    assign mode_write = bus.wr && bus.addr == ADDR_TIMER_MODE;

    // Register write path; compare writes may land mid-count
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            port3_direction <= RESET_PORT3_DIRECTION;
            port3_latch <= RESET_PORT3_LATCH;
            compare_value <= RESET_COMPARE;
            output_enable_bit <= 1'b0;
            output_toggle_enable <= 1'b0;
            count_clk_sel <= 2'b00;
            edge_sel <= 2'b00;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                ADDR_PORT3_DIRECTION:
                    port3_direction <= bus.wdata | PORT3_DIRECTION_FIXED;
                ADDR_PORT3_LATCH:
                    port3_latch <= bus.wdata;
                ADDR_COMPARE_LO:
                    compare_value[7:0] <= bus.wdata;
                ADDR_COMPARE_HI:
                    compare_value[15:8] <= bus.wdata;
                ADDR_TIMER_MODE:
                begin
                    output_enable_bit <= bus.wdata[OUTPUT_ENABLE_POS];
                    output_toggle_enable <= bus.wdata[TOGGLE_ENABLE_POS];
                    count_clk_sel <= bus.wdata[CLK_SEL_LO_POS +: 2];
                    edge_sel <= bus.wdata[EDGE_SEL_LO_POS +: 2];
                end
                default:
                    port3_latch <= port3_latch;
            endcase
        end
    end

    // Count clock: prescaler taps or synchronised neighbour tick
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            prescale <= 5'h00;
        else
            prescale <= prescale + 5'h01;
    end

    // Tick synchroniser runs through reset, so a tick idling high
    // gives no false count after release
    always_ff @(posedge ref_clk)
    begin
        tick_sync <= {tick_sync[0], ext_count_tick};
        tick_prev <= tick_sync[1];
    end

    always_comb
    begin
        case (count_clk_t'(count_clk_sel))
            CLK_EXT_TICK: count_tick = tick_sync[1] && !tick_prev;
            CLK_DIV1: count_tick = 1'b1;
            CLK_DIV4: count_tick = (prescale & DIV4_MASK) == DIV4_MASK;
            CLK_DIV32: count_tick = prescale == DIV32_MASK;
            default: count_tick = 1'b0;
        endcase
    end

    // Free-running counter; reset restarts it from zero at once
    // Stop-mode behaviour is not modelled; value is simply kept
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            free_counter <= RESET_COUNTER;
        else if (count_tick)
            free_counter <= free_counter + 16'h0001;
    end

    // Wrap flag: hardware set beats a simultaneous software clear
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            wrap_flag <= 1'b0;
        else if (count_tick && free_counter == 16'hffff)
            wrap_flag <= 1'b1;
        else if (mode_write && !bus.wdata[WRAP_FLAG_POS])
            wrap_flag <= 1'b0;
    end

    // Match on rising equality, so a compare write can also fire
    assign match_now = free_counter == compare_value;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            match_prev <= 1'b0;
            bus.match_irq <= 1'b0;
        end
        else
        begin
            match_prev <= match_now;
            bus.match_irq <= match_now && !match_prev;
        end
    end

    // Output level: forced low as enable rises, toggled per match
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            output_level_bit <= 1'b0;
        else if (mode_write && bus.wdata[OUTPUT_ENABLE_POS]
            && !output_enable_bit)
            output_level_bit <= 1'b0;
        else if (match_now && !match_prev && output_toggle_enable
            && output_enable_bit)
            output_level_bit <= !output_level_bit;
    end

    // Shared pin: timer or port latch, buffer on when direction is 0
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            shared_pin_out <= 1'b0;
            shared_pin_oe <= 1'b0;
        end
        else
        begin
            shared_pin_out <= output_enable_bit ? output_level_bit
                : port3_latch[SHARED_PIN_POS];
            shared_pin_oe <= !port3_direction[SHARED_PIN_POS];
        end
    end

    // Capture pin: two flops, then a third for the edge compare; left
    // running through reset so a pin idling high gives no false edge
    always_ff @(posedge ref_clk)
    begin
        pin_sync <= {pin_sync[0], shared_pin_in};
        pin_prev <= pin_sync[1];
    end

    always_comb
    begin
        case (edge_sel_t'(edge_sel))
            EDGE_NONE: capture_edge = 1'b0;
            EDGE_RISE: capture_edge = pin_sync[1] && !pin_prev;
            EDGE_FALL: capture_edge = !pin_sync[1] && pin_prev;
            EDGE_BOTH: capture_edge = pin_sync[1] != pin_prev;
            default: capture_edge = 1'b0;
        endcase
    end

    // Capture is not blocked by reads; software must gate edges
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            capture_value <= RESET_CAPTURE;
        else if (capture_edge)
            capture_value <= free_counter;
    end

    // Read buffer tracks the counter unless a byte pair is open
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            buffer_frozen <= 1'b0;
            read_buffer <= RESET_COUNTER;
            rd_prev <= 1'b0;
            last_rd_addr <= 16'h0000;
        end
        else
        begin
            rd_prev <= bus.rd;
            if (bus.rd)
                last_rd_addr <= bus.addr;
            if (!buffer_frozen)
                read_buffer <= free_counter;
            if (bus.rd && !rd_prev && bus.addr == ADDR_COUNTER_LO)
                buffer_frozen <= 1'b1;
            else if (!bus.rd && rd_prev
                && last_rd_addr == ADDR_COUNTER_HI)
                buffer_frozen <= 1'b0;
        end
    end

    // Read data registered while the read strobe stands
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            bus.rdata <= 8'h00;
        else if (bus.rd)
        begin
            case (bus.addr)
                ADDR_PORT3_DIRECTION:
                    bus.rdata <= port3_direction | PORT3_DIRECTION_FIXED;
                ADDR_PORT3_LATCH:
                    bus.rdata <= port3_latch;
                ADDR_TIMER_MODE:
                    bus.rdata <= {output_level_bit, wrap_flag, edge_sel,
                        output_toggle_enable, count_clk_sel,
                        output_enable_bit};
                ADDR_COUNTER_LO: bus.rdata <= read_buffer[7:0];
                ADDR_COUNTER_HI: bus.rdata <= read_buffer[15:8];
                ADDR_COMPARE_LO: bus.rdata <= compare_value[7:0];
                ADDR_COMPARE_HI: bus.rdata <= compare_value[15:8];
                ADDR_CAPTURE_LO: bus.rdata <= capture_value[7:0];
                ADDR_CAPTURE_HI: bus.rdata <= capture_value[15:8];
                default: bus.rdata <= 8'h00;
            endcase
        end
    end
endmodule : compare_capture_timer

/* File: src/timer_pkg.sv */
// Constants shared by the compare/capture timer and its cpu end
package timer_pkg;
    // Byte addresses on the register bus
    localparam logic [15:0] ADDR_PORT3_DIRECTION = 16'hff23;
    localparam logic [15:0] ADDR_PORT3_LATCH = 16'hff03;
    localparam logic [15:0] ADDR_TIMER_MODE = 16'hff48;
    localparam logic [15:0] ADDR_COUNTER_LO = 16'hff12;
    localparam logic [15:0] ADDR_COUNTER_HI = 16'hff13;
    localparam logic [15:0] ADDR_COMPARE_LO = 16'hff16;
    localparam logic [15:0] ADDR_COMPARE_HI = 16'hff17;
    localparam logic [15:0] ADDR_CAPTURE_LO = 16'hff18;
    localparam logic [15:0] ADDR_CAPTURE_HI = 16'hff19;
    // Reset values and the fixed direction bits
    localparam logic [7:0] RESET_PORT3_DIRECTION = 8'hff;
    localparam logic [7:0] PORT3_DIRECTION_FIXED = 8'he0;
    localparam logic [7:0] RESET_PORT3_LATCH = 8'h00;
    localparam logic [15:0] RESET_COUNTER = 16'h0000;
    localparam logic [15:0] RESET_COMPARE = 16'hffff;
    localparam logic [15:0] RESET_CAPTURE = 16'h0000;
    // Field positions in timer_mode_control
    localparam int OUTPUT_ENABLE_POS = 0;
    localparam int CLK_SEL_LO_POS = 1;
    localparam int TOGGLE_ENABLE_POS = 3;
    localparam int EDGE_SEL_LO_POS = 4;
    localparam int WRAP_FLAG_POS = 6;
    localparam int OUTPUT_LEVEL_POS = 7;
    // Shared pin position within port 3
    localparam int SHARED_PIN_POS = 3;
    // Position of the match mask inside irq_mask_reg_b
    localparam int MATCH_IRQ_MASK_POS = 2;
    localparam logic [7:0] RESET_IRQ_MASK_REG_B = 8'hff;
    // Main clock dividers for the count clock
    localparam logic [4:0] DIV4_MASK = 5'h03;
    localparam logic [4:0] DIV32_MASK = 5'h1f;

    typedef enum logic [1:0]
    {
        CLK_EXT_TICK = 2'b00,
        CLK_DIV1 = 2'b01,
        CLK_DIV4 = 2'b10,
        CLK_DIV32 = 2'b11
    } count_clk_t;

    typedef enum logic [1:0]
    {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_sel_t;
endpackage : timer_pkg

/* File: src/timer_bus_if.sv */
// Byte-wide register bus between the cpu end and the timer
`timescale 1ns/1ps
interface timer_bus_if;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    logic match_irq;

    modport timer
    (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata,
        output match_irq
    );

    modport cpu
    (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata,
        input match_irq
    );
endinterface : timer_bus_if

/* File: src/timer_cpu_end.sv */
// Cpu end: byte-pair bus sequencer and match interrupt masking
`timescale 1ns/1ps
module timer_cpu_end
(
    input wire logic ref_clk,
    input wire logic reset,
    timer_bus_if.cpu bus,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_wide,
    input wire logic [15:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_ready,
    output logic resp_valid,
    output logic [15:0] resp_data,
    input wire logic mask_write,
    input wire logic [7:0] mask_wdata,
    output logic irq_out
);
    import timer_pkg::*;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_WRITE = 3'b001,
        ST_GAP = 3'b010,
        ST_READ = 3'b011,
        ST_HOLD = 3'b100,
        ST_SAMPLE = 3'b101
    } cpu_state_t;

    cpu_state_t state;
    logic [7:0] irq_mask_reg_b;
    logic [15:0] base_addr;
    logic [15:0] wdata_hold;
    logic is_write;
    logic second;
    logic wide;

    // Wide writes go high byte first, wide reads low byte first
    function automatic logic [15:0] byte_addr(input logic [15:0] base,
        input logic wr, input logic sec);
        logic hi;
        hi = wr ? !sec : sec;
        byte_addr = base + {15'h0000, hi};
    endfunction : byte_addr

    // Byte sequencer; one write strobe, two-cycle read strobe
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state <= ST_IDLE;
            cmd_ready <= 1'b1;
            resp_valid <= 1'b0;
            resp_data <= 16'h0000;
            bus.addr <= 16'h0000;
            bus.wdata <= 8'h00;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            base_addr <= 16'h0000;
            wdata_hold <= 16'h0000;
            is_write <= 1'b0;
            second <= 1'b0;
            wide <= 1'b0;
        end
        else
        begin
            resp_valid <= 1'b0;
            case (state)
                ST_IDLE:
                    if (cmd_valid)
                    begin
                        cmd_ready <= 1'b0;
                        base_addr <= cmd_addr;
                        wdata_hold <= cmd_wdata;
                        is_write <= cmd_write;
                        wide <= cmd_wide;
                        second <= 1'b0;
                        bus.addr <= byte_addr(cmd_addr, cmd_write && cmd_wide,
                            1'b0);
                        bus.wdata <= cmd_wide ? cmd_wdata[15:8]
                            : cmd_wdata[7:0];
                        bus.wr <= cmd_write;
                        bus.rd <= !cmd_write;
                        state <= cmd_write ? ST_WRITE : ST_READ;
                    end
                ST_WRITE:
                begin
                    bus.wr <= 1'b0;
                    state <= ST_GAP;
                end
                ST_READ:
                    state <= ST_HOLD;
                ST_HOLD:
                begin
                    bus.rd <= 1'b0;
                    state <= ST_SAMPLE;
                end
                ST_SAMPLE:
                begin
                    if (second)
                        resp_data[15:8] <= bus.rdata;
                    else
                        resp_data <= {8'h00, bus.rdata};
                    state <= ST_GAP;
                end
                ST_GAP:
                    if (wide && !second)
                    begin
                        second <= 1'b1;
                        bus.addr <= byte_addr(base_addr, is_write, 1'b1);
                        bus.wdata <= wdata_hold[7:0];
                        bus.wr <= is_write;
                        bus.rd <= !is_write;
                        state <= is_write ? ST_WRITE : ST_READ;
                    end
                    else
                    begin
                        resp_valid <= 1'b1;
                        cmd_ready <= 1'b1;
                        state <= ST_IDLE;
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Interrupt mask; mask set blocks match requests
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            irq_mask_reg_b <= RESET_IRQ_MASK_REG_B;
            irq_out <= 1'b0;
        end
        else
        begin
            if (mask_write)
                irq_mask_reg_b <= mask_wdata;
            irq_out <= bus.match_irq
                && !irq_mask_reg_b[MATCH_IRQ_MASK_POS];
        end
    end
endmodule : timer_cpu_end

/* File: sim/timer_bus_asserts.sv */
// Checker for the byte bus between the cpu end and the timer
`timescale 1ns/1ps
module timer_bus_asserts
    import timer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic match_irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // Strobe shapes and spacing
    wr_one_cycle_a: assert property (wr |=> !wr)
        else $error("write strobe longer than one cycle");
    rd_two_cycles_a: assert property ($rose(rd) |=> rd ##1 !rd)
        else $error("read strobe not held two cycles");
    rd_wr_apart_a: assert property (!(wr && rd))
        else $error("read and write strobes together");
    rd_addr_steady_a: assert property ($rose(rd) |=> $stable(addr))
        else $error("address moved during a read");
    // Read data only moves after a sampled read strobe
    rdata_hold_a: assert property (!$past(rd) |-> $stable(rdata))
        else $error("read data changed without a read");
    // A match request is a single pulse; constant compare gives one per wrap
    irq_single_a: assert property (match_irq |=> !match_irq)
        else $error("match request longer than one cycle");
    // Counter bytes go low then high, four cycles apart
    hi_after_lo_a: assert property ($rose(rd) && addr == ADDR_COUNTER_HI
        |-> $past(addr, 4) == ADDR_COUNTER_LO)
        else $error("counter high byte read without low byte");
    // Wide compare writes put the high byte first
    cmp_hi_first_a: assert property (wr && addr == ADDR_COMPARE_LO
        |-> $past(wr, 2) && $past(addr, 2) == ADDR_COMPARE_HI)
        else $error("compare low byte written before high byte");
endmodule : timer_bus_asserts

/* File: sim/tb_top.sv */
// Self-checking bench: cpu end and timer joined over the bus interface
`timescale 1ns/1ps
module tb_top;
    import timer_pkg::*;
    logic ref_clk = 0, reset = 1, ext_count_tick = 0, shared_pin_in = 0;
    logic shared_pin_out, shared_pin_oe, cmd_ready, resp_valid, irq_out;
    logic cmd_valid = 0, cmd_write = 0, cmd_wide = 0, mask_write = 0;
    logic [15:0] cmd_addr = 16'h0000, cmd_wdata = 16'h0000, resp_data, r;
    logic [7:0] mask_wdata = 8'hff;
    int num_errors = 0, n_checks = 0, cyc = 0, t1;

    timer_bus_if bus_if();
    compare_capture_timer compare_capture_timer_i (.ref_clk(ref_clk),
        .reset(reset), .bus(bus_if), .ext_count_tick(ext_count_tick),
        .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out),
        .shared_pin_oe(shared_pin_oe));
    timer_cpu_end timer_cpu_end_i (.ref_clk(ref_clk), .reset(reset),
        .bus(bus_if), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_wide(cmd_wide), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_data(resp_data), .mask_write(mask_write),
        .mask_wdata(mask_wdata), .irq_out(irq_out));
    timer_bus_asserts timer_bus_asserts_i (.ref_clk(ref_clk),
        .reset(reset), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .rdata(bus_if.rdata), .wr(bus_if.wr), .rd(bus_if.rd),
        .match_irq(bus_if.match_irq));

    // Clock and hang guard; the interval test alone needs 65536 cycles
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            num_errors++;
            $display("MISMATCH %0t run did not finish", $time);
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One command through the cpu end; held until taken, then await answer
    task automatic op(input logic w, input logic wide,
        input logic [15:0] a, input logic [15:0] d);
        int i;
        cmd_write = w;
        cmd_wide = wide;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1;
        for (i = 0; i < 40 && cmd_ready !== 1'b1; i++)
            @(posedge ref_clk) #1;
        @(posedge ref_clk) #1;
        cmd_valid = 0;
        for (i = 0; i < 40 && resp_valid !== 1'b1; i++)
            @(posedge ref_clk) #1;
        if (resp_valid !== 1'b1)
        begin
            num_errors++;
            $display("MISMATCH %0t no response to command", $time);
        end
        r = resp_data;
    endtask : op

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk) #1;
    endtask : idle

    // Direction register reset, fixed top bits, pin buffer, unmapped read
    task automatic t_direction();
        op(0, 0, ADDR_PORT3_DIRECTION, 16'h0000);
        check(r[7:0], 8'hff);
        check(shared_pin_oe, 1'b0);
        op(1, 0, ADDR_PORT3_DIRECTION, 16'h0000);
        op(0, 0, ADDR_PORT3_DIRECTION, 16'h0000);
        check(r[7:0], 8'he0);
        idle(2);
        check(shared_pin_oe, 1'b1);
        op(0, 0, 16'hff00, 16'h0000);
        check(r[7:0], 8'h00);
    endtask : t_direction

    // Counter idles at zero on the external tick, then counts its rises
    task automatic t_count();
        op(0, 1, ADDR_COUNTER_LO, 16'h0000);
        check(r, 16'h0000);
        repeat (3)
        begin
            ext_count_tick = 1;
            idle(3);
            ext_count_tick = 0;
            idle(3);
        end
        idle(4);
        op(0, 1, ADDR_COUNTER_LO, 16'h0000);
        check(r, 16'h0003);
    endtask : t_count

    // Drive the capture pin, let sync and load settle, read the capture
    task automatic pin_cap(input logic lvl, input logic [15:0] exp);
        shared_pin_in = lvl;
        idle(6);
        op(0, 1, ADDR_CAPTURE_LO, 16'h0000);
        check(r, exp);
    endtask : pin_cap

    task automatic t_capture();
        op(1, 0, ADDR_PORT3_DIRECTION, 16'h0008);
        check(shared_pin_oe, 1'b0);
        op(1, 0, ADDR_TIMER_MODE, 16'h0010);
        pin_cap(1, 16'h0003);
        ext_count_tick = 1;
        idle(3);
        ext_count_tick = 0;
        pin_cap(0, 16'h0003);
        op(1, 0, ADDR_TIMER_MODE, 16'h0030);
        pin_cap(1, 16'h0004);
        op(1, 0, ADDR_TIMER_MODE, 16'h0000);
        pin_cap(0, 16'h0004);
    endtask : t_capture

    task automatic wait_irq();
        int i;
        for (i = 0; i < 70000 && irq_out !== 1'b1; i++)
            @(posedge ref_clk) #1;
        check(irq_out, 1'b1);
    endtask : wait_irq

    // Toggled output, match interval, wrap flag and read-only level bit
    task automatic t_output();
        int t2;
        op(1, 0, ADDR_PORT3_LATCH, 16'h0008);
        check(shared_pin_out, 1'b1);
        op(1, 0, ADDR_PORT3_LATCH, 16'h0000);
        op(1, 0, ADDR_PORT3_DIRECTION, 16'h0000);
        op(1, 1, ADDR_COMPARE_LO, 16'h0010);
        mask_write = 1;
        mask_wdata = 8'hfb;
        idle(1);
        mask_write = 0;
        op(1, 0, ADDR_TIMER_MODE, 16'h000b);
        check(shared_pin_out, 1'b0);
        check(shared_pin_oe, 1'b1);
        wait_irq();
        t1 = cyc;
        idle(2);
        check(shared_pin_out, 1'b1);
        op(0, 0, ADDR_TIMER_MODE, 16'h0000);
        check(r[7:6], 2'b10);
        idle(2);
        wait_irq();
        t2 = cyc;
        n_checks++;
        if (t2 - t1 != 65536)
        begin
            num_errors++;
            $display("MISMATCH %0t match interval %0d", $time, t2 - t1);
        end
        idle(2);
        check(shared_pin_out, 1'b0);
        op(0, 0, ADDR_TIMER_MODE, 16'h0000);
        check(r[7:6], 2'b01);
        op(1, 0, ADDR_TIMER_MODE, 16'h008b);
        op(0, 0, ADDR_TIMER_MODE, 16'h0000);
        check(r[7:6], 2'b00);
    endtask : t_output

    // Main sequence
    initial
    begin
        repeat (8) @(posedge ref_clk);
        #1 reset = 0;
        idle(1);
        t_direction();
        t_count();
        t_capture();
        t_output();
        results();
    end
endmodule : tb_top
